/* rtl/qrw_pkg.sv */
// package: constants and types for the quad rail reset watchdog
package qrw_pkg;
  // clock rate and derived cycle counts
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned WDT_MS         = 610;
  localparam int unsigned DLY_LONG_MS    = 300;
  localparam int unsigned DLY_SHORT_MS   = 20;
  localparam int unsigned WDT_CYC        = WDT_MS * (CLK_HZ / 1000);
  localparam int unsigned DLY_LONG_CYC   = DLY_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned DLY_SHORT_CYC  = DLY_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned PROG_DLY_RST   = 32'h0001_86a0;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned NUM_CH         = 4;

  // axi register map, byte addresses
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_PROG0     = 8'h10;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [7:0]  CTRL_RST       = 8'h00;

  // delay mode per channel, two bits each in the control word
  typedef enum logic [1:0] {
    QRW_DLY_LONG  = 2'h0,
    QRW_DLY_SHORT = 2'h1,
    QRW_DLY_PROG  = 2'h2
  } qrw_dly_t;
endpackage : qrw_pkg

/* rtl/qrw_top.sv */
// module: four-channel supervisor with release delays and hang timer
`timescale 1ns/1ps
// Function
// - release only after the channel delay
// - assert channel reset immediately on condition
// - channel one releases on manual high, rail ok
// - manual reset low asserts channel one
// - channel two follows rail two level
// - channel three follows rail three level
// - channel four releases only inside window
// - build option selects output polarity
// - no kick for 610ms raises fault
// - no timeout while channel one asserted
// - fault stays latched despite kicks
// - only channel one reset clears fault
// - hang timer starts at channel one release
// - every kick edge restarts the countdown
// - delay mode long, short or programmable
module qrw_top
  import qrw_pkg::*;
#(
  parameter bit          ACTIVE_HIGH = 1'b0,       // output polarity option
  parameter int unsigned WDT_CYCLES  = WDT_CYC,    // hang timeout in cycles
  parameter int unsigned LONG_CYCLES = DLY_LONG_CYC, // long delay in cycles
  parameter int unsigned SHORT_CYCLES = DLY_SHORT_CYC // short delay in cycles
) (
  input  wire logic        aclk,                   // 25 MHz clock
  input  wire logic        aresetn,                // sync reset, low active
  input  wire logic        clk_en,                 // freezes state when low
  input  wire logic        manual_reset_in_n,      // manual reset, low active
  input  wire logic        rail_one_level,         // rail one above threshold
  input  wire logic        rail_two_level,         // rail two above threshold
  input  wire logic        rail_three_level,       // rail three above threshold
  input  wire logic        window_low_side_level,  // above falling threshold
  input  wire logic        window_high_side_level, // above rising threshold
  input  wire logic        watchdog_kick_in,       // kick pin
  output logic [3:0]       channel_reset_out,      // channel resets, index 0 is primary
  output logic             watchdog_fault_out,     // hang fault
  input  wire logic [7:0]  s_axi_awaddr,           // write address
  input  wire logic        s_axi_awvalid,          // write address valid
  output logic             s_axi_awready,          // write address ready
  input  wire logic [31:0] s_axi_wdata,            // write data
  input  wire logic [3:0]  s_axi_wstrb,            // write strobes
  input  wire logic        s_axi_wvalid,           // write data valid
  output logic             s_axi_wready,           // write data ready
  output logic [1:0]       s_axi_bresp,            // write response
  output logic             s_axi_bvalid,           // write response valid
  input  wire logic        s_axi_bready,           // write response ready
  input  wire logic [7:0]  s_axi_araddr,           // read address
  input  wire logic        s_axi_arvalid,          // read address valid
  output logic             s_axi_arready,          // read address ready
  output logic [31:0]      s_axi_rdata,            // read data
  output logic [1:0]       s_axi_rresp,            // read response
  output logic             s_axi_rvalid,           // read data valid
  input  wire logic        s_axi_rready            // read data ready
);

  if (WDT_CYCLES < 2 || LONG_CYCLES < 1 || SHORT_CYCLES < 1 ||
      WDT_CYCLES > 32'hffff_fff0) begin : g_bad_cfg
    $error("qrw_top: unusable cycle counts");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic       kick_prev_ff;
  wire  [5:0] raw_in = {watchdog_kick_in, window_high_side_level, window_low_side_level,
                        rail_three_level, rail_two_level, rail_one_level};

  // two flops on every pin flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff     <= 6'h00;
      sync2_ff     <= 6'h00;
      kick_prev_ff <= 1'b0;
    end else if (clk_en) begin
      sync1_ff     <= raw_in;
      sync2_ff     <= sync1_ff;
      kick_prev_ff <= sync2_ff[5];
    end
  end

  logic manual_sync1_ff;
  logic manual_sync2_ff;
  // manual reset resets to asserted (low)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      manual_sync1_ff <= 1'b0;
      manual_sync2_ff <= 1'b0;
    end else if (clk_en) begin
      manual_sync1_ff <= manual_reset_in_n;
      manual_sync2_ff <= manual_sync1_ff;
    end
  end

  wire kick_edge = sync2_ff[5] ^ kick_prev_ff;

  // release conditions per channel
  logic [3:0] rel_ok;
  always_comb begin
    rel_ok[0] = manual_sync2_ff & sync2_ff[0];
    rel_ok[1] = sync2_ff[1];
    rel_ok[2] = sync2_ff[2];
    rel_ok[3] = sync2_ff[3] & ~sync2_ff[4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0]       ctrl_ff;
  logic [CNT_W-1:0] prog_ff [NUM_CH];
  logic [3:0]       asserted_ff;
  logic             fault_ff;

  logic       aw_hold_ff;
  logic       w_hold_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  wire wr_go     = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  wire wr_prog   = awaddr_ff[7:4] == ADDR_PROG0[7:4] && awaddr_ff[1:0] == 2'h0;
  wire wr_hit    = awaddr_ff == ADDR_CTRL || wr_prog;

  // ready while nothing held, response once both taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_hold_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_ff && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control word: delay mode per channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
    end else if (clk_en && wr_go && awaddr_ff == ADDR_CTRL && wstrb_ff[0]) begin
      ctrl_ff <= wdata_ff[7:0];
    end
  end

  // programmable delays, one word per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_prog
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prog_ff[c] <= PROG_DLY_RST;
      end else if (clk_en && wr_go && wr_prog && awaddr_ff[3:2] == 2'(c)) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_ff[b])
            prog_ff[c][8*b +: 8] <= wdata_ff[8*b +: 8];
        end
      end
    end
  end

  // read side
  logic [31:0] nxt_rdata;
  logic        nxt_rerr;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rerr  = 1'b0;
    if (s_axi_araddr == ADDR_CTRL)
      nxt_rdata = {24'h000000, ctrl_ff};
    else if (s_axi_araddr == ADDR_STATUS)
      nxt_rdata = {23'h000000, fault_ff, asserted_ff, rel_ok};
    else if (s_axi_araddr[7:4] == ADDR_PROG0[7:4] && s_axi_araddr[1:0] == 2'h0)
      nxt_rdata = prog_ff[s_axi_araddr[3:2]];
    else
      nxt_rerr = 1'b1;
  end

  // one read at a time, answer the cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= nxt_rdata;
        s_axi_rresp  <= nxt_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supervisor channels
  logic [CNT_W-1:0] dly_cnt_ff [NUM_CH];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    qrw_dly_t         mode;
    logic [CNT_W-1:0] target;
    always_comb begin
      mode = qrw_dly_t'(ctrl_ff[2*c +: 2]);
      case (mode)
        QRW_DLY_LONG:  target = CNT_W'(LONG_CYCLES);
        QRW_DLY_SHORT: target = CNT_W'(SHORT_CYCLES);
        QRW_DLY_PROG:  target = (prog_ff[c] == '0) ? CNT_W'(1) : prog_ff[c];
        default:       target = CNT_W'(LONG_CYCLES);
      endcase
    end

    // next asserted state, so the pin tracks without an extra cycle
    logic nxt_asserted;
    assign nxt_asserted = !rel_ok[c] || (asserted_ff[c] && (dly_cnt_ff[c] + 1'b1 < target));

    // assert at once, release after counted delay
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        asserted_ff[c] <= 1'b1;
        dly_cnt_ff[c]  <= '0;
      end else if (clk_en) begin
        if (!rel_ok[c]) begin
          asserted_ff[c] <= 1'b1;
          dly_cnt_ff[c]  <= '0;
        end else if (asserted_ff[c]) begin
          if (dly_cnt_ff[c] + 1'b1 >= target)
            asserted_ff[c] <= 1'b0;
          else
            dly_cnt_ff[c] <= dly_cnt_ff[c] + 1'b1;
        end
      end
    end

    // pin level from polarity option
    always_ff @(posedge aclk) begin
      if (!aresetn)
        channel_reset_out[c] <= ACTIVE_HIGH;
      else if (clk_en)
        channel_reset_out[c] <= ACTIVE_HIGH ? nxt_asserted : ~nxt_asserted;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hang timer on channel one
  logic [CNT_W-1:0] wdt_cnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_cnt_ff <= '0;
      fault_ff   <= 1'b0;
    end else if (clk_en) begin
      if (asserted_ff[0]) begin
        wdt_cnt_ff <= '0;
        fault_ff   <= 1'b0;
      end else if (!fault_ff) begin
        if (kick_edge)
          wdt_cnt_ff <= '0;
        else if (wdt_cnt_ff + 1'b1 >= CNT_W'(WDT_CYCLES))
          fault_ff <= 1'b1;
        else
          wdt_cnt_ff <= wdt_cnt_ff + 1'b1;
      end
    end
  end

  // fault pin with polarity option
  always_ff @(posedge aclk) begin
    if (!aresetn)
      watchdog_fault_out <= ~ACTIVE_HIGH;
    else if (clk_en)
      watchdog_fault_out <= ACTIVE_HIGH ? fault_ff : ~fault_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_assert_fast;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && !rel_ok[1]) |=> asserted_ff[1];
  endproperty
  a_assert_fast: assert property (p_assert_fast) else $error("channel not asserted");

  property p_manual_holds;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && !manual_sync2_ff) |=> asserted_ff[0];
  endproperty
  a_manual_holds: assert property (p_manual_holds) else $error("manual reset ignored");

  property p_window;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && sync2_ff[4]) |=> asserted_ff[3];
  endproperty
  a_window: assert property (p_window) else $error("window high side ignored");

  property p_no_early_release;
    @(posedge aclk) disable iff (!aresetn)
      $fell(asserted_ff[2]) |-> $past(dly_cnt_ff[2]) + 1 >= $past(g_ch[2].target);
  endproperty
  a_no_early_release: assert property (p_no_early_release) else $error("early release");

  property p_fault_latched;
    @(posedge aclk) disable iff (!aresetn)
      (fault_ff && !asserted_ff[0]) |=> fault_ff;
  endproperty
  a_fault_latched: assert property (p_fault_latched) else $error("fault cleared");

  property p_fault_clear;
    @(posedge aclk) disable iff (!aresetn)
      $fell(fault_ff) |-> $past(asserted_ff[0]);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault cleared wrongly");

  property p_no_fault_in_reset;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && asserted_ff[0]) |=> !fault_ff;
  endproperty
  a_no_fault_in_reset: assert property (p_no_fault_in_reset) else $error("fault in reset");

  property p_kick_restart;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && kick_edge && !fault_ff && !asserted_ff[0]) |=> wdt_cnt_ff == '0;
  endproperty
  a_kick_restart: assert property (p_kick_restart) else $error("kick not restarting");

  property p_pin_polarity;
    @(posedge aclk) disable iff (!aresetn)
      clk_en |=> watchdog_fault_out == (ACTIVE_HIGH ? $past(fault_ff) : !$past(fault_ff));
  endproperty
  a_pin_polarity: assert property (p_pin_polarity) else $error("fault pin polarity");

endmodule : qrw_top

/* dv/qrw_host_model.sv */
// partner: processor that kicks the hang timer while out of reset
`timescale 1ns/1ps
module qrw_host_model (
  input  wire logic        aclk,              // bench clock
  input  wire logic        aresetn,           // sync reset, low active
  input  wire logic        primary_reset_out, // channel one reset, low = held
  input  wire logic        kick_en,           // bench allows kicking
  input  wire logic [15:0] kick_ivl,          // kick edges come kick_ivl + 1 cycles apart
  output logic             watchdog_kick_in   // kick line to the block
);
  logic [15:0] cnt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // toggle the kick only while running; a held or hung processor stays quiet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff           <= 16'h0;
      watchdog_kick_in <= 1'b0;
    end else if (!primary_reset_out || !kick_en) begin
      cnt_ff <= 16'h0;
    end else if (cnt_ff >= kick_ivl) begin
      cnt_ff           <= 16'h0;
      watchdog_kick_in <= ~watchdog_kick_in;
    end else begin
      cnt_ff <= cnt_ff + 16'h1;
    end
  end
endmodule // qrw_host_model

/* dv/tb_top.sv */
// testbench: random and corner checks of the quad rail reset watchdog
`timescale 1ns/1ps
module tb_top;
  import qrw_pkg::*;
  localparam int WDT = 200;
  localparam int LNG = 50;
  localparam int SHT = 20;
  localparam logic [5:0] GOOD = 6'h1f; // {high side, low side, rail3, rail2, rail1, manual}
  logic        aclk = 1'b0, aresetn = 1'b0, kick, kick_en = 1'b1, ce = 1'b1;
  logic [5:0]  cond = 6'h20;
  logic [15:0] ivl = 16'h40;
  logic [3:0]  rst_o;
  logic        fault, awr, wr, bv, arr, rv;
  logic [7:0]  awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rdat, rd;
  logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [1:0]  br, rr, resp;
  int          failures = 0, cmp_count = 0, cyc = 0, n0, n1, d[4];

  always #20 aclk = ~aclk;

  qrw_top #(.WDT_CYCLES(WDT), .LONG_CYCLES(LNG), .SHORT_CYCLES(SHT)) i_qrw_top (
    .aclk(aclk), .aresetn(aresetn), .clk_en(ce), .manual_reset_in_n(cond[0]),
    .rail_one_level(cond[1]), .rail_two_level(cond[2]), .rail_three_level(cond[3]),
    .window_low_side_level(cond[4]), .window_high_side_level(cond[5]),
    .watchdog_kick_in(kick), .channel_reset_out(rst_o), .watchdog_fault_out(fault),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy));

  qrw_host_model i_qrw_host_model (
    .aclk(aclk), .aresetn(aresetn), .primary_reset_out(rst_o[0]), .kick_en(kick_en),
    .kick_ivl(ivl), .watchdog_kick_in(kick));

  ////////////////////////////////////////////////////////////////////////////
  // comparison, verdict and hang guard
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    check({31'h0, (n >= lo && n <= hi)}, 32'h1);
  endtask

  task automatic results();
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // expected release delay for a channel's mode
  function automatic int exp_dly(input logic [1:0] m, input logic [31:0] p);
    if (m == 2'h1) return SHT;
    if (m == 2'h2) return (p == 32'h0) ? 1 : int'(p);
    return LNG;
  endfunction

  // outputs expected right after one cause is broken
  function automatic logic [3:0] exp_mask(input int i);
    case (i)
      0, 1: return 4'he;
      2: return 4'hd;
      3: return 4'hb;
      default: return 4'h7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awr === 1'b1) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (!tw && wr === 1'b1) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge aclk); while (bv !== 1'b1);
    r = br;
    brdy <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    v = rd;
    r = rr;
    rrdy <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // cycles until a channel output shows released
  task automatic meas(input int ch, output int n);
    n = 0;
    while (rst_o[ch] !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // restore every condition and time each held channel
  task automatic release_all();
    int n[4];
    logic [3:0] m;
    m = ~rst_o;
    @(posedge aclk);
    cond <= GOOD;
    fork
      meas(0, n[0]);
      meas(1, n[1]);
      meas(2, n[2]);
      meas(3, n[3]);
    join
    for (int c = 0; c < 4; c++) begin
      if (m[c]) chk_rng(n[c], d[c], d[c] + 6);
    end
  endtask

  // hold everything down, program modes and delays, then release
  task automatic run_pass(input logic [7:0] ctrl);
    logic [31:0] pv;
    @(posedge aclk);
    cond <= 6'h20;
    ivl <= 16'h8 + 16'($urandom % 150);
    axi_wr(ADDR_CTRL, {24'h0, ctrl}, resp);
    check(resp, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      pv = 32'($urandom % 40);
      axi_wr(ADDR_PROG0 + 8'(4 * c), pv, resp);
      d[c] = exp_dly(ctrl[2*c +: 2], pv);
    end
    axi_rd(ADDR_CTRL, rdat, resp);
    check(rdat[7:0], ctrl);
    check(rst_o, 4'h0);
    release_all();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h5e7a));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(rst_o, 4'h0);
    check(fault, 1'b1);
    run_pass(8'he4);
    // a dip before the short delay ends restarts it
    @(posedge aclk);
    cond <= GOOD ^ 6'h4;
    repeat (6) @(posedge aclk);
    cond <= GOOD;
    repeat (10) @(posedge aclk);
    cond <= GOOD ^ 6'h4;
    repeat (3) @(posedge aclk);
    cond <= GOOD;
    meas(1, n1);
    chk_rng(n1, SHT, SHT + 6);
    run_pass(8'($urandom));
    // each cause asserts only its own channel, at once
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      cond <= GOOD ^ (6'h1 << i);
      repeat (6) @(posedge aclk);
      check(rst_o, exp_mask(i));
      release_all();
    end
    // a low clock enable freezes pins and counts
    @(posedge aclk);
    ce <= 1'b0;
    cond <= GOOD ^ 6'h4;
    repeat (10) @(posedge aclk);
    check(rst_o, 4'hf);
    ce <= 1'b1;
    repeat (6) @(posedge aclk);
    check(rst_o, 4'hd);
    release_all();
    // hang timer
    kick_en <= 1'b1;
    repeat (3 * WDT) @(posedge aclk);
    check(fault, 1'b1);
    @(kick);
    @(posedge aclk);
    kick_en <= 1'b0;
    n0 = 0;
    while (fault !== 1'b0 && n0 < 3000) begin
      @(posedge aclk);
      n0++;
    end
    chk_rng(n0, WDT, WDT + 8);
    kick_en <= 1'b1;
    repeat (3 * WDT) @(posedge aclk);
    check(fault, 1'b0);
    axi_rd(ADDR_STATUS, rdat, resp);
    check(rdat, 32'h0000_010f);
    cond <= GOOD ^ 6'h1;
    kick_en <= 1'b0;
    repeat (6) @(posedge aclk);
    check(fault, 1'b1);
    cond <= GOOD ^ 6'h2;
    repeat (2 * WDT) @(posedge aclk);
    check(fault, 1'b1);
    cond <= GOOD;
    meas(0, n0);
    n1 = 0;
    while (fault !== 1'b0 && n1 < 3000) begin
      @(posedge aclk);
      n1++;
    end
    chk_rng(n1, WDT - 2, WDT + 4);
    // unmapped places answer with an error
    axi_rd(8'h40, rdat, resp);
    check(resp, RESP_SLVERR);
    check(rdat, 32'h0);
    axi_wr(8'h44, 32'h5a, resp);
    check(resp, RESP_SLVERR);
    results();
  end
endmodule // tb_top
